// ### hw/dt_cfg.svh
// constants for the descriptor table unit: field positions, reset values, fills
// assumes descriptors arrive as two 32-bit words, lower word at offset +0
`ifndef DESC_CFG_SVH
`define DESC_CFG_SVH
`define SEL_TBL 2
`define SEL_IDX 15:3
`define ENT_ONES 3'h7
`define ENT_ZERO 3'h0
`define OFF_HI_ZERO 16'h0000
`define IDX_NULL 13'h0000
`define VEC_BITS 7:0
`define VEC_PAD 5'h00
`define VEC_HI_ZERO 21'h000000
`define TBL_BASE 47:16
`define TBL_LIM 15:0
`define SEL_HI_ZERO 32'h0000_0000
`define RES_ZERO 48'h0000_0000_0000
`define CPL_SUPER 2'h0
`define RST_BASE 32'h0000_0000
`define RST_LIM16 16'h0000
`define RST_LIM32 32'h0000_0000
`define RST_SEL 16'h0000
`define D_BASE_HI 31:24
`define D_BASE_MID 7:0
`define D_BASE_LO 31:16
`define D_LIM_HI 19:16
`define D_LIM_LO 15:0
`define D_G 23
`define D_D 22
`define D_SPARE 20
`define D_P 15
`define D_PRIV 14:13
`define D_KIND 12
`define D_TYPE 11:8
`define T_E 3
`define T_CD 2
`define T_RW 1
`define T_A 0
`define PAGE_FILL 12'hFFF
`define BYTE_FILL 12'h000
`define SYS_T16_IDLE 4'h1
`define SYS_LOCAL_T 4'h2
`define SYS_T16_BUSY 4'h3
`define SYS_T32_IDLE 4'h9
`define SYS_T32_BUSY 4'hB
`endif

// ### hw/dt_pkg.sv
// types shared by the descriptor table unit and its descriptor decoder
// assumes dt_cfg.svh supplies all numeric constants
`default_nettype none
package desc_pkg;
    typedef enum logic [2:0] {
        OP_LOAD_GLOBAL, OP_LOAD_INTR, OP_LOAD_LOCAL, OP_STORE_GLOBAL,
        OP_STORE_INTR, OP_STORE_LOCAL, OP_LOAD_SEG, OP_INTR_ENTRY
    } op_t;
    typedef enum logic [2:0] {
        F_NONE, F_PRIV, F_MODE, F_LIMIT, F_KIND, F_ABSENT, F_NO_LOCAL
    } fault_t;
    typedef enum logic [2:0] {
        SYS_NONE, SYS_TASK16_IDLE, SYS_LOCAL, SYS_TASK16_BUSY,
        SYS_TASK32_IDLE, SYS_TASK32_BUSY
    } sys_kind_t;
endpackage
`default_nettype wire

// ### hw/seg_desc_decode.sv
// combinational decoder for an 8-byte segment descriptor
// assumes hi word is the one at offset +4, lo word the one at +0
`timescale 1ns/1ps
`default_nettype none
`include "dt_cfg.svh"
module seg_desc_decode (
    input wire logic [31:0] desc_hi_in,
    input wire logic [31:0] desc_lo_in,
    output logic [31:0] base_out,
    output logic [31:0] limit_out,
    output logic app_out,
    output logic present_out,
    output logic [1:0] priv_out,
    output logic [3:0] type_out,
    output logic big_out,
    output logic exp_down_out,
    output logic conform_out,
    output logic rw_out,
    output logic accessed_out,
    output logic spare_out,
    output desc_pkg::sys_kind_t sys_kind_out
);
    import desc_pkg::*;

    logic [19:0] raw_lim;
    logic exec;

    // ==========================================
    // base, limit and flags
    assign base_out = {desc_hi_in[`D_BASE_HI], desc_hi_in[`D_BASE_MID],
                       desc_lo_in[`D_BASE_LO]}; // [R15]
    assign raw_lim = {desc_hi_in[`D_LIM_HI], desc_lo_in[`D_LIM_LO]};
    // page units cover the whole last page, so the low bits fill with ones
    assign limit_out = desc_hi_in[`D_G] ? {raw_lim, `PAGE_FILL}
                                        : {`BYTE_FILL, raw_lim}; // [R16]
    assign app_out = desc_hi_in[`D_KIND]; // [R18]
    assign present_out = desc_hi_in[`D_P]; // [R23]
    assign priv_out = desc_hi_in[`D_PRIV]; // [R23]
    assign type_out = desc_hi_in[`D_TYPE];
    assign spare_out = desc_hi_in[`D_SPARE];
    assign exec = type_out[`T_E];
    // size bit only means something for code and stack (data) segments
    assign big_out = app_out & desc_hi_in[`D_D]; // [R17]
    assign exp_down_out = app_out & ~exec & type_out[`T_CD]; // [R20]
    assign conform_out = app_out & exec & type_out[`T_CD]; // [R21]
    assign rw_out = app_out & type_out[`T_RW]; // [R22]
    assign accessed_out = app_out & type_out[`T_A]; // [R22]

    // ==========================================
    // system type decode
    always_comb begin
        sys_kind_out = SYS_NONE;
        if (!app_out) begin
            case (type_out) // [R19]
                `SYS_T16_IDLE: sys_kind_out = SYS_TASK16_IDLE;
                `SYS_LOCAL_T: sys_kind_out = SYS_LOCAL;
                `SYS_T16_BUSY: sys_kind_out = SYS_TASK16_BUSY;
                `SYS_T32_IDLE: sys_kind_out = SYS_TASK32_IDLE;
                `SYS_T32_BUSY: sys_kind_out = SYS_TASK32_BUSY;
                default: sys_kind_out = SYS_NONE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### hw/descriptor_table_unit.sv
// descriptor table registers, selector lookup and descriptor fetch
// assumes one 64-bit descriptor read per request, answered by MEM_ACK_IN
`timescale 1ns/1ps
`default_nettype none
`include "dt_cfg.svh"
// Function
// (R01) global table register keeps 32-bit base and 16-bit limit
// (R02) interrupt table register keeps 32-bit base and 16-bit limit
// (R03) interrupt table has 256 entries, one per vector
// (R04) global table indexed as up to 8192 eight-byte descriptors
// (R05) table indicator 0 looks the selector up in the global table
// (R06) table indicator 1 looks the selector up in the local table
// (R07) global entry zero is the null descriptor, never fetched
// (R08) local selector load indexes a descriptor held in the global table
// (R09) local selector load fetches and caches base and limit
// (R10) local accesses use the cache until the selector is reloaded
// (R11) global and interrupt loads need privilege 0 in protected mode
// (R12) local selector load and store only in protected mode
// (R13) global and interrupt stores return full base and limit
// (R14) system descriptors only from global table, application from either
// (R15) base assembled from hi 31-24, hi 7-0, lo 31-16
// (R16) limit from hi 19-16 and lo 15-0, granularity picks units
// (R17) size bit 22 picks 16 or 32 bit for code and stack
// (R18) bit 12 marks system when 0, application when 1
// (R19) system type codes decode to task state and local kinds
// (R20) data direction bit set means expand down
// (R21) executable conforming bit set runs at caller privilege
// (R22) lowest type bit is accessed, next grants write or read
// (R23) present bit 15 and privilege bits 14-13 kept for checks
module descriptor_table_unit (
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    input wire logic OP_VALID_IN,
    input wire desc_pkg::op_t OP_CODE_IN,
    input wire logic [47:0] OP_DATA_IN,
    input wire logic PROT_MODE_IN,
    input wire logic [1:0] CPL_IN,
    input wire logic [63:0] MEM_RDATA_IN,
    input wire logic MEM_ACK_IN,
    output logic BUSY_OUT,
    output logic DONE_OUT,
    output logic FAULT_OUT,
    output desc_pkg::fault_t FAULT_CODE_OUT,
    output logic [47:0] RESULT_OUT,
    output logic MEM_REQ_OUT,
    output logic [31:0] MEM_ADDR_OUT,
    output logic [31:0] LOCAL_BASE_OUT,
    output logic [31:0] LOCAL_LIMIT_OUT,
    output logic SEG_NULL_OUT,
    output logic [31:0] SEG_BASE_OUT,
    output logic [31:0] SEG_LIMIT_OUT,
    output logic SEG_APP_OUT,
    output logic SEG_PRESENT_OUT,
    output logic [1:0] SEG_PRIV_OUT,
    output logic [3:0] SEG_TYPE_OUT,
    output logic SEG_BIG_OUT,
    output logic SEG_EXP_DOWN_OUT,
    output logic SEG_CONFORM_OUT,
    output logic SEG_RW_OUT,
    output logic SEG_ACCESSED_OUT,
    output logic SEG_SPARE_OUT,
    output desc_pkg::sys_kind_t SEG_SYS_KIND_OUT
);
    import desc_pkg::*;

    typedef enum logic {ST_IDLE, ST_FETCH} state_t;

    state_t st_q;
    op_t op_q;
    logic tbl_local_q;
    logic [15:0] pend_sel_q;
    logic busy_q;
    logic mem_req_q;
    logic [31:0] mem_addr_q;
    logic [31:0] gl_base_q;
    logic [15:0] gl_lim_q;
    logic [31:0] iv_base_q;
    logic [15:0] iv_lim_q;
    logic [15:0] lo_sel_q;
    logic [31:0] lo_base_q;
    logic [31:0] lo_lim_q;
    logic lo_valid_q;
    logic done_q;
    logic fault_q;
    fault_t fcode_q;
    logic [47:0] result_q;
    logic seg_null_q;
    logic [31:0] seg_base_q;
    logic [31:0] seg_lim_q;
    logic seg_app_q;
    logic seg_present_q;
    logic [1:0] seg_priv_q;
    logic [3:0] seg_type_q;
    logic seg_big_q;
    logic seg_exp_q;
    logic seg_conf_q;
    logic seg_rw_q;
    logic seg_acc_q;
    logic seg_spare_q;
    sys_kind_t seg_sys_q;

    logic [15:0] sel;
    logic [12:0] idx;
    logic tbl_ind;
    logic null_sel;
    logic [7:0] vec;
    logic [31:0] ent_off;
    logic [31:0] gl_addr;
    logic [31:0] lo_addr;
    logic [31:0] iv_addr;
    logic gl_fit;
    logic lo_fit;
    logic iv_fit;
    logic take;
    logic ack;

    logic [31:0] d_base;
    logic [31:0] d_limit;
    logic d_app;
    logic d_present;
    logic [1:0] d_priv;
    logic [3:0] d_type;
    logic d_big;
    logic d_exp;
    logic d_conf;
    logic d_rw;
    logic d_acc;
    logic d_spare;
    sys_kind_t d_sys;

    fault_t iss_f;
    logic iss_fetch;
    logic [31:0] iss_addr;
    logic iss_local;
    logic [47:0] iss_res;
    fault_t chk_f;

    // ==========================================
    // selector and vector lookup
    assign take = OP_VALID_IN && (st_q == ST_IDLE);
    assign ack = (st_q == ST_FETCH) && MEM_ACK_IN;
    assign sel = OP_DATA_IN[`TBL_LIM];
    assign idx = sel[`SEL_IDX];
    assign tbl_ind = sel[`SEL_TBL];
    assign null_sel = (idx == `IDX_NULL); // [R07]
    assign vec = OP_DATA_IN[`VEC_BITS];
    assign ent_off = {`OFF_HI_ZERO, idx, `ENT_ZERO}; // [R04]
    assign gl_addr = gl_base_q + ent_off; // [R05]
    assign lo_addr = lo_base_q + ent_off; // [R06] [R10]
    assign iv_addr = iv_base_q + {`VEC_HI_ZERO, vec, `ENT_ZERO}; // [R03]
    // the whole 8-byte entry must sit inside the limit
    assign gl_fit = {idx, `ENT_ONES} <= gl_lim_q; // [R04]
    assign lo_fit = {`OFF_HI_ZERO, idx, `ENT_ONES} <= lo_lim_q; // [R10]
    assign iv_fit = {`VEC_PAD, vec, `ENT_ONES} <= iv_lim_q; // [R03]

    seg_desc_decode u_dec (
        .desc_hi_in(MEM_RDATA_IN[63:32]),
        .desc_lo_in(MEM_RDATA_IN[31:0]),
        .base_out(d_base),
        .limit_out(d_limit),
        .app_out(d_app),
        .present_out(d_present),
        .priv_out(d_priv),
        .type_out(d_type),
        .big_out(d_big),
        .exp_down_out(d_exp),
        .conform_out(d_conf),
        .rw_out(d_rw),
        .accessed_out(d_acc),
        .spare_out(d_spare),
        .sys_kind_out(d_sys)
    );

    // ==========================================
    // request checks at issue
    always_comb begin
        iss_f = F_NONE;
        iss_fetch = 1'b0;
        iss_addr = gl_addr;
        iss_local = 1'b0;
        case (OP_CODE_IN)
            OP_LOAD_GLOBAL, OP_LOAD_INTR: begin
                if (PROT_MODE_IN && CPL_IN != `CPL_SUPER) iss_f = F_PRIV; // [R11]
            end
            OP_LOAD_LOCAL: begin
                if (!PROT_MODE_IN) begin
                    iss_f = F_MODE; // [R12]
                end else if (tbl_ind) begin
                    iss_f = F_KIND; // [R08]
                end else if (!null_sel) begin
                    if (!gl_fit) iss_f = F_LIMIT;
                    else iss_fetch = 1'b1; // [R08]
                end
            end
            OP_STORE_LOCAL: begin
                if (!PROT_MODE_IN) iss_f = F_MODE; // [R12]
            end
            OP_LOAD_SEG: begin
                if (tbl_ind) begin
                    if (!lo_valid_q) begin
                        iss_f = F_NO_LOCAL;
                    end else if (!lo_fit) begin
                        iss_f = F_LIMIT;
                    end else begin
                        iss_fetch = 1'b1; // [R06]
                        iss_addr = lo_addr;
                        iss_local = 1'b1;
                    end
                end else if (!null_sel) begin
                    if (!gl_fit) iss_f = F_LIMIT;
                    else iss_fetch = 1'b1; // [R05]
                end
            end
            OP_INTR_ENTRY: begin
                if (!iv_fit) iss_f = F_LIMIT; // [R03]
            end
            default: iss_f = F_NONE;
        endcase
    end

    always_comb begin
        case (OP_CODE_IN)
            OP_STORE_GLOBAL: iss_res = {gl_base_q, gl_lim_q}; // [R13]
            OP_STORE_INTR: iss_res = {iv_base_q, iv_lim_q}; // [R13]
            OP_STORE_LOCAL: iss_res = {`SEL_HI_ZERO, lo_sel_q};
            OP_INTR_ENTRY: iss_res = {`OFF_HI_ZERO, iv_addr};
            default: iss_res = `RES_ZERO;
        endcase
    end

    // ==========================================
    // descriptor checks on arrival
    always_comb begin
        chk_f = F_NONE;
        if (op_q == OP_LOAD_LOCAL) begin
            if (d_app || d_sys != SYS_LOCAL) chk_f = F_KIND; // [R08]
            else if (!d_present) chk_f = F_ABSENT;
        end else if (tbl_local_q && !d_app) begin
            chk_f = F_KIND; // [R14]
        end
    end

    // ==========================================
    // sequencing and memory request
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_q <= ST_IDLE;
            op_q <= OP_LOAD_SEG;
            tbl_local_q <= 1'b0;
            pend_sel_q <= `RST_SEL;
            busy_q <= 1'b0;
            mem_req_q <= 1'b0;
            mem_addr_q <= `RST_BASE;
        end else if (take && iss_f == F_NONE && iss_fetch) begin
            st_q <= ST_FETCH;
            op_q <= OP_CODE_IN;
            tbl_local_q <= iss_local;
            pend_sel_q <= sel;
            busy_q <= 1'b1;
            mem_req_q <= 1'b1;
            mem_addr_q <= iss_addr;
        end else if (ack) begin
            st_q <= ST_IDLE;
            busy_q <= 1'b0;
            mem_req_q <= 1'b0;
        end
    end

    // ==========================================
    // global and interrupt table registers
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            gl_base_q <= `RST_BASE;
            gl_lim_q <= `RST_LIM16;
            iv_base_q <= `RST_BASE;
            iv_lim_q <= `RST_LIM16;
        end else if (take && iss_f == F_NONE) begin
            if (OP_CODE_IN == OP_LOAD_GLOBAL) begin
                gl_base_q <= OP_DATA_IN[`TBL_BASE]; // [R01]
                gl_lim_q <= OP_DATA_IN[`TBL_LIM]; // [R01]
            end
            if (OP_CODE_IN == OP_LOAD_INTR) begin
                iv_base_q <= OP_DATA_IN[`TBL_BASE]; // [R02]
                iv_lim_q <= OP_DATA_IN[`TBL_LIM]; // [R02]
            end
        end
    end

    // ==========================================
    // local table selector and hidden cache
    // the cache only changes on a reload, never on later memory writes
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            lo_sel_q <= `RST_SEL;
            lo_base_q <= `RST_BASE;
            lo_lim_q <= `RST_LIM32;
            lo_valid_q <= 1'b0;
        end else if (take && OP_CODE_IN == OP_LOAD_LOCAL && iss_f == F_NONE
                     && !iss_fetch) begin
            lo_sel_q <= sel; // [R07]
            lo_valid_q <= 1'b0;
        end else if (ack && op_q == OP_LOAD_LOCAL && chk_f == F_NONE) begin
            lo_sel_q <= pend_sel_q;
            lo_base_q <= d_base; // [R09]
            lo_lim_q <= d_limit; // [R09]
            lo_valid_q <= 1'b1; // [R10]
        end
    end

    // ==========================================
    // completion and result
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            done_q <= 1'b0;
            fault_q <= 1'b0;
            fcode_q <= F_NONE;
            result_q <= `RES_ZERO;
        end else if (take && !(iss_f == F_NONE && iss_fetch)) begin
            done_q <= 1'b1;
            fault_q <= (iss_f != F_NONE);
            fcode_q <= iss_f;
            result_q <= (iss_f == F_NONE) ? iss_res : `RES_ZERO;
        end else if (ack) begin
            done_q <= 1'b1;
            fault_q <= (chk_f != F_NONE);
            fcode_q <= chk_f;
            result_q <= `RES_ZERO;
        end else begin
            done_q <= 1'b0;
            fault_q <= 1'b0;
        end
    end

    // ==========================================
    // decoded segment descriptor
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            seg_null_q <= 1'b1;
            seg_base_q <= `RST_BASE;
            seg_lim_q <= `RST_LIM32;
            seg_app_q <= 1'b0;
            seg_present_q <= 1'b0;
            seg_priv_q <= `CPL_SUPER;
            seg_type_q <= `SYS_T16_IDLE;
            seg_big_q <= 1'b0;
            seg_exp_q <= 1'b0;
            seg_conf_q <= 1'b0;
            seg_rw_q <= 1'b0;
            seg_acc_q <= 1'b0;
            seg_spare_q <= 1'b0;
            seg_sys_q <= SYS_NONE;
        end else if (take && OP_CODE_IN == OP_LOAD_SEG && iss_f == F_NONE
                     && !iss_fetch) begin
            seg_null_q <= 1'b1; // [R07]
            seg_present_q <= 1'b0;
        end else if (ack && op_q == OP_LOAD_SEG && chk_f == F_NONE) begin
            seg_null_q <= 1'b0;
            seg_base_q <= d_base; // [R15]
            seg_lim_q <= d_limit; // [R16]
            seg_app_q <= d_app; // [R18]
            seg_present_q <= d_present; // [R23]
            seg_priv_q <= d_priv; // [R23]
            seg_type_q <= d_type;
            seg_big_q <= d_big; // [R17]
            seg_exp_q <= d_exp; // [R20]
            seg_conf_q <= d_conf; // [R21]
            seg_rw_q <= d_rw; // [R22]
            seg_acc_q <= d_acc; // [R22]
            seg_spare_q <= d_spare;
            seg_sys_q <= d_sys; // [R19]
        end
    end

    assign BUSY_OUT = busy_q;
    assign DONE_OUT = done_q;
    assign FAULT_OUT = fault_q;
    assign FAULT_CODE_OUT = fcode_q;
    assign RESULT_OUT = result_q;
    assign MEM_REQ_OUT = mem_req_q;
    assign MEM_ADDR_OUT = mem_addr_q;
    assign LOCAL_BASE_OUT = lo_base_q;
    assign LOCAL_LIMIT_OUT = lo_lim_q;
    assign SEG_NULL_OUT = seg_null_q;
    assign SEG_BASE_OUT = seg_base_q;
    assign SEG_LIMIT_OUT = seg_lim_q;
    assign SEG_APP_OUT = seg_app_q;
    assign SEG_PRESENT_OUT = seg_present_q;
    assign SEG_PRIV_OUT = seg_priv_q;
    assign SEG_TYPE_OUT = seg_type_q;
    assign SEG_BIG_OUT = seg_big_q;
    assign SEG_EXP_DOWN_OUT = seg_exp_q;
    assign SEG_CONFORM_OUT = seg_conf_q;
    assign SEG_RW_OUT = seg_rw_q;
    assign SEG_ACCESSED_OUT = seg_acc_q;
    assign SEG_SPARE_OUT = seg_spare_q;
    assign SEG_SYS_KIND_OUT = seg_sys_q;

    // ==========================================
    // checks
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    sequence s_take(op_t c);
        st_q == ST_IDLE && OP_VALID_IN && OP_CODE_IN == c;
    endsequence

    sequence s_ok_done;
        done_q && !fault_q;
    endsequence

    AST_NULL_SEL: assert property ( // [R07]
        (s_take(OP_LOAD_SEG) ##0 (!tbl_ind && null_sel))
        |=> (s_ok_done ##0 (seg_null_q && !mem_req_q)))
        else $error("null selector fetched or not flagged");

    AST_PRIV_LOAD: assert property ( // [R11]
        (s_take(OP_LOAD_GLOBAL) ##0 (PROT_MODE_IN && CPL_IN != `CPL_SUPER))
        |=> (fault_q && fcode_q == F_PRIV && $stable(gl_base_q)))
        else $error("unprivileged global load not refused");

    AST_LOCAL_MODE: assert property ( // [R12]
        (st_q == ST_IDLE && OP_VALID_IN && !PROT_MODE_IN
         && (OP_CODE_IN == OP_LOAD_LOCAL || OP_CODE_IN == OP_STORE_LOCAL))
        |=> (fault_q && fcode_q == F_MODE))
        else $error("local selector access outside protected mode");

    AST_GLOBAL_FETCH: assert property ( // [R05]
        (s_take(OP_LOAD_SEG) ##0 (!tbl_ind && !null_sel && gl_fit))
        |=> (mem_req_q && busy_q && !done_q
             && mem_addr_q == $past(gl_base_q) + $past(ent_off)))
        else $error("global descriptor address wrong");

    AST_LOCAL_FETCH: assert property ( // [R06]
        (s_take(OP_LOAD_SEG) ##0 (tbl_ind && lo_valid_q && lo_fit))
        |=> (mem_req_q && mem_addr_q == $past(lo_base_q) + $past(ent_off)))
        else $error("local descriptor address wrong");

    AST_SYS_LOCAL: assert property ( // [R14]
        (ack && op_q == OP_LOAD_SEG && tbl_local_q && !d_app)
        |=> (fault_q && fcode_q == F_KIND && !mem_req_q))
        else $error("system descriptor taken from local table");

    AST_CACHE_LOAD: assert property ( // [R09]
        (ack && op_q == OP_LOAD_LOCAL && d_sys == SYS_LOCAL && d_present)
        |=> (lo_valid_q && lo_base_q == $past(d_base) && lo_lim_q == $past(d_limit)))
        else $error("local cache not filled from descriptor");

    AST_CACHE_HOLD: assert property ( // [R10]
        (!(ack && op_q == OP_LOAD_LOCAL)) |=> $stable(lo_base_q))
        else $error("local cache changed without reload");

    AST_STORE_GLOBAL: assert property ( // [R13]
        s_take(OP_STORE_GLOBAL)
        |=> (s_ok_done ##0 (result_q == {$past(gl_base_q), $past(gl_lim_q)})))
        else $error("global store result wrong");
endmodule
`default_nettype wire

// ### testbench/tb_descriptor_table_unit.sv
// self-checking bench for the descriptor table unit
// assumes the design files under hw/ are compiled first; the bench answers memory itself
`timescale 1ns/1ps
`default_nettype none
module tb_descriptor_table_unit;
    import desc_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic MCLK_IN = 1'b0;
    logic RST_N_IN = 1'b0;
    logic OP_VALID_IN = 1'b0;
    op_t OP_CODE_IN = OP_STORE_GLOBAL;
    logic [47:0] OP_DATA_IN = 48'h0;
    logic PROT_MODE_IN = 1'b1;
    logic [1:0] CPL_IN = 2'h0;
    logic [63:0] MEM_RDATA_IN = 64'h0;
    logic MEM_ACK_IN = 1'b0;
    logic BUSY_OUT, DONE_OUT, FAULT_OUT, MEM_REQ_OUT, SEG_NULL_OUT, SEG_APP_OUT;
    logic SEG_PRESENT_OUT, SEG_BIG_OUT, SEG_EXP_DOWN_OUT, SEG_CONFORM_OUT;
    logic SEG_RW_OUT, SEG_ACCESSED_OUT, SEG_SPARE_OUT;
    logic [1:0] SEG_PRIV_OUT;
    logic [3:0] SEG_TYPE_OUT;
    logic [47:0] RESULT_OUT;
    logic [31:0] MEM_ADDR_OUT, LOCAL_BASE_OUT, LOCAL_LIMIT_OUT, SEG_BASE_OUT, SEG_LIMIT_OUT;
    fault_t FAULT_CODE_OUT;
    sys_kind_t SEG_SYS_KIND_OUT;
    wire logic [13:0] seg_flags = {SEG_APP_OUT, SEG_PRESENT_OUT, SEG_PRIV_OUT, SEG_TYPE_OUT,
        SEG_BIG_OUT, SEG_EXP_DOWN_OUT, SEG_CONFORM_OUT, SEG_RW_OUT, SEG_ACCESSED_OUT,
        SEG_SPARE_OUT};
    int n_fail = 0;
    int comparisons = 0;
    logic fetched;
    logic [31:0] addr_seen;
    logic [3:0] f_seen;
    logic busy_seen;
    localparam logic [47:0] GT = {32'h0001_0000, 16'h00FF};
    localparam logic [63:0] D1 = 64'h12DA_D634_5678_BCDE;
    localparam logic [63:0] D2 = 64'h0000_9F00_0000_0010;
    localparam logic [63:0] LD = 64'h0000_8203_0000_001F;
    logic [3:0] sys_code [5] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'hB};
    sys_kind_t sys_exp [5] = '{SYS_TASK16_IDLE, SYS_LOCAL, SYS_TASK16_BUSY, SYS_TASK32_IDLE,
        SYS_TASK32_BUSY};

    descriptor_table_unit dut (.*);

    always #25 MCLK_IN = ~MCLK_IN;

    // ==========================================================
    // shared tasks
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic ef(input fault_t f);
        chk("fault", f_seen, {f != F_NONE, f});
    endtask

    // the fetch is answered one cycle late, and read data is scrambled outside the ack
    task automatic run(input op_t c, input logic [47:0] d, input logic [63:0] m);
        int i;
        int w;
        fetched = 1'b0;
        w = 0;
        @(negedge MCLK_IN);
        OP_VALID_IN = 1'b1;
        OP_CODE_IN = c;
        OP_DATA_IN = d;
        @(negedge MCLK_IN);
        OP_VALID_IN = 1'b0;
        for (i = 0; i < 20 && DONE_OUT !== 1'b1; i++) begin
            if (MEM_REQ_OUT === 1'b1) w++;
            MEM_ACK_IN = (w == 2);
            MEM_RDATA_IN = MEM_ACK_IN ? m : ~m;
            if (MEM_ACK_IN) begin
                fetched = 1'b1;
                addr_seen = MEM_ADDR_OUT;
                busy_seen = BUSY_OUT;
            end
            @(negedge MCLK_IN);
        end
        MEM_ACK_IN = 1'b0;
        MEM_RDATA_IN = ~m;
        chk("done", DONE_OUT, 1'b1);
        f_seen = {FAULT_OUT, FAULT_CODE_OUT};
    endtask

    task automatic finish_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // test sequence
    initial begin
        repeat (10) @(posedge MCLK_IN);
        @(negedge MCLK_IN);
        RST_N_IN = 1'b1;
        chk("null_rst", SEG_NULL_OUT, 1'b1);
        run(OP_STORE_GLOBAL, 48'h0, 64'h0);
        chk("gt_rst", RESULT_OUT, 48'h0);
        run(OP_LOAD_GLOBAL, GT, 64'h0);
        run(OP_STORE_GLOBAL, 48'h0, 64'h0);
        chk("gt", RESULT_OUT, GT);
        run(OP_LOAD_INTR, {32'h0004_0000, 16'h07FF}, 64'h0);
        run(OP_STORE_INTR, 48'h0, 64'h0);
        chk("it", RESULT_OUT, {32'h0004_0000, 16'h07FF});
        CPL_IN = 2'h3;
        run(OP_LOAD_GLOBAL, 48'h1, 64'h0);
        ef(F_PRIV);
        run(OP_LOAD_INTR, 48'h1, 64'h0);
        ef(F_PRIV);
        run(OP_STORE_GLOBAL, 48'h0, 64'h0);
        chk("gt_kept", RESULT_OUT, GT);
        PROT_MODE_IN = 1'b0;
        run(OP_LOAD_INTR, {32'h0002_0000, 16'h07F7}, 64'h0);
        ef(F_NONE);
        run(OP_LOAD_LOCAL, 48'h10, LD);
        ef(F_MODE);
        run(OP_STORE_LOCAL, 48'h0, 64'h0);
        ef(F_MODE);
        PROT_MODE_IN = 1'b1;
        CPL_IN = 2'h0;
        run(OP_INTR_ENTRY, 48'hFE, 64'h0);
        chk("entry", RESULT_OUT, {16'h0, 32'h0002_07F0});
        run(OP_INTR_ENTRY, 48'hFF, 64'h0);
        ef(F_LIMIT);
        run(OP_LOAD_SEG, 48'h3, D1);
        chk("null", {SEG_NULL_OUT, fetched}, 2'h2);
        run(OP_LOAD_SEG, 48'hF8, D1);
        chk("addr_g", addr_seen, 32'h0001_00F8);
        chk("busy", {busy_seen, BUSY_OUT}, 2'h2);
        chk("base", SEG_BASE_OUT, 32'h1234_5678);
        chk("limit", SEG_LIMIT_OUT, 32'hABCD_EFFF);
        chk("flags", seg_flags, 14'h39B5);
        run(OP_LOAD_SEG, 48'h100, D1);
        chk("over", {f_seen, fetched}, {1'b1, F_LIMIT, 1'b0});
        run(OP_LOAD_SEG, 48'hC, D2);
        ef(F_NO_LOCAL);
        run(OP_LOAD_LOCAL, 48'h10, LD);
        chk("addr_l", addr_seen, 32'h0001_0010);
        chk("cache", {LOCAL_BASE_OUT, LOCAL_LIMIT_OUT}, 64'h0003_0000_0000_001F);
        run(OP_STORE_LOCAL, 48'h0, 64'h0);
        chk("sel", RESULT_OUT, 48'h10);
        run(OP_LOAD_SEG, 48'h1C, D2);
        chk("addr_lt", addr_seen, 32'h0003_0018);
        chk("code", {seg_flags, SEG_LIMIT_OUT}, {14'h33CE, 32'h10});
        run(OP_LOAD_SEG, 48'h24, D2);
        ef(F_LIMIT);
        run(OP_LOAD_SEG, 48'hC, LD);
        ef(F_KIND);
        run(OP_LOAD_LOCAL, 48'h18, D1);
        chk("bad_ld", {f_seen, LOCAL_BASE_OUT}, {1'b1, F_KIND, 32'h0003_0000});
        run(OP_LOAD_LOCAL, 48'h14, LD);
        chk("ld_ti", {f_seen, fetched}, {1'b1, F_KIND, 1'b0});
        run(OP_LOAD_LOCAL, 48'h10, {LD[63:48], 1'b0, LD[46:0]});
        ef(F_ABSENT);
        run(OP_LOAD_LOCAL, 48'h0, LD);
        run(OP_LOAD_SEG, 48'hC, D2);
        chk("ld_null", {f_seen, fetched}, {1'b1, F_NO_LOCAL, 1'b0});
        for (int k = 0; k < 5; k++) begin
            run(OP_LOAD_SEG, 48'h8, {20'h00008, sys_code[k], 40'h0});
            chk("sys", {SEG_APP_OUT, SEG_SYS_KIND_OUT}, {1'b0, sys_exp[k]});
        end
        finish_test();
    end

    // ==========================================================
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #(50 * 4000);
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
